//--- lpi_core.sv
// led blink phase select and 240-step pwm intensity generator
//
// Behaviour
// RQ1: blink off: levels from phase-zero register only
// RQ2: blink on: flip xor pin picks phase register
// RQ3: period is 15 timeslots of 16 cycles
// RQ4: master value gates 1 to 15 timeslots
// RQ5: 4-bit intensity sets duty within gated timeslots
// RQ6: intensity 16/16 gives static glitch-free output
// RQ7: phase bit 0 spans 1/16 to fully on
// RQ8: phase bit 1 spans off to 15/16
// RQ9: phase-zero register at 0x02, read/write
// RQ10: phase-one register at 0x0A, read/write
// RQ11: ninth intensity doubles as global intensity
// RQ12: global mode: master plus ninth form 8 bits
// RQ13: global mode applies to every output
// RQ14: master nibble zero: all outputs static
// RQ15: software picks 0xF static, 0x0-0xE pwm
// RQ16: global mode ignores per-port intensity registers
// RQ17: bit 1 is high impedance, 0 drives low
// RQ18: blink enable clear ignores flip flag
// RQ19: 32 kHz tick stops when pwm unused
// RQ20: off-time gives inverse level, on-time first
// RQ21: settings take effect at cycle boundary
`timescale 1ns/10ps
module lpi_core
  import lpi_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       blink_in,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] port_out,
  output logic      [7:0] port_oe,
  output logic            ninth_out,
  output logic            ninth_oe,
  output logic            pwm_running
);
  import lpi_pkg::*;

  logic [7:0]  phase_zero_q, phase_one_q, master_q, config_q, rdata_q;
  logic [31:0] port_int_q;
  logic [7:0]  ph0_s, ph1_s, mst_s, cfg_s;
  logic [31:0] int_s;
  logic [8:0]  div_q;
  logic [3:0]  cyc_q, slot_q;
  logic [8:0]  oe_q;
  logic        osc_run, tick, boundary, pwm_on;
  logic [8:0]  sel_w, level_w;
  logic [3:0]  eff_int [NUM_OUT];

  function automatic logic [3:0] nib(input logic [31:0] v, input int idx);
    nib = v[idx*4 +: 4];
  endfunction

  function automatic logic pick(input logic en, input logic flip, input logic pin,
                                input logic p0, input logic p1);
    pick = (en && (flip ^ pin)) ? p1 : p0;
  endfunction

  // per-port intensity bytes occupy four consecutive offsets
  function automatic logic is_int_addr(input logic [7:0] a);
    is_int_addr = (a >= REG_PORT_INT_0) && (a <= REG_PORT_INT_3);
  endfunction

  // on-time sits at the start of every gated timeslot
  function automatic logic in_on_time(input logic [3:0] slot, input logic [3:0] cyc,
                                      input logic [3:0] mst,  input logic [3:0] lvl);
    in_on_time = (slot < mst) && (cyc <= lvl);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_zero_q <= PHASE_RST;
      phase_one_q  <= PHASE_RST;
      master_q     <= MASTER_RST;
      config_q     <= CONFIG_RST;
      port_int_q   <= INT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_PHASE_ZERO:   phase_zero_q <= reg_wdata; // see RQ9
        REG_PHASE_ONE:    phase_one_q  <= reg_wdata; // see RQ10
        REG_MASTER_NINTH: master_q     <= reg_wdata;
        REG_CONFIG:       config_q     <= reg_wdata;
        default: begin
          if (is_int_addr(reg_addr)) begin
            port_int_q[8*(reg_addr[1:0]) +: 8] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // phase, master and intensity reads give stored values, not the pin condition
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_PHASE_ZERO:   rdata_q <= phase_zero_q; // see RQ9
        REG_PHASE_ONE:    rdata_q <= phase_one_q; // see RQ10
        REG_MASTER_NINTH: rdata_q <= master_q;
        // bit 6 reads the blink pin itself, so it can serve as a plain input
        REG_CONFIG: begin
          rdata_q <= config_q & 8'h3F;
          rdata_q[CFG_BLINK_STAT] <= blink_in;
        end
        default: begin
          if (is_int_addr(reg_addr)) begin
            rdata_q <= port_int_q[8*(reg_addr[1:0]) +: 8];
          end else begin
            rdata_q <= 8'h00;
          end
        end
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // pwm oscillator: divided tick, held still when no pwm is wanted
  // 312 clocks per tick runs slightly fast of the nominal rate; no fraction kept
  assign osc_run = (master_q[7:4] != 4'h0); // see RQ14
  assign tick    = osc_run && (div_q == OSC_LAST); // see RQ19
  assign pwm_running = osc_run;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 9'h000;
    end else if (!osc_run || tick) begin
      div_q <= 9'h000; // see RQ19
    end else begin
      div_q <= div_q + 9'h001;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_q  <= 4'h0;
      slot_q <= 4'h0;
    end else if (!osc_run) begin
      cyc_q  <= 4'h0;
      slot_q <= 4'h0;
    end else if (tick) begin
      cyc_q <= cyc_q + 4'h1; // see RQ3
      if (cyc_q == CYC_LAST) begin
        slot_q <= (slot_q == SLOT_LAST) ? 4'h0 : slot_q + 4'h1; // see RQ3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadow copies: a write mid-cycle would cut a runt pulse
  assign boundary = !osc_run || (tick && cyc_q == CYC_LAST);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph0_s <= PHASE_RST;
      ph1_s <= PHASE_RST;
      mst_s <= MASTER_RST;
      cfg_s <= CONFIG_RST;
      int_s <= INT_RST;
    end else if (boundary) begin
      ph0_s <= phase_zero_q; // see RQ21
      ph1_s <= phase_one_q;
      mst_s <= master_q;
      cfg_s <= config_q;
      int_s <= port_int_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output levels
  assign pwm_on = (mst_s[7:4] != 4'h0);

  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      // global flag swaps in the ninth nibble for every output
      eff_int[i] = cfg_s[CFG_GLOBAL] ? mst_s[3:0] : // see RQ11, RQ13, RQ16
                   ((i == NUM_OUT - 1) ? mst_s[3:0] : nib(int_s, i));
    end
  end

  // blink pin is used live: it is the blink clock and must not wait for a boundary
  always_comb begin
    sel_w = 9'h000;
    for (int i = 0; i < 8; i++) begin
      sel_w[i] = pick(cfg_s[CFG_BLINK_EN], cfg_s[CFG_BLINK_FLIP], // see RQ1, RQ2, RQ18
                      blink_in, ph0_s[i], ph1_s[i]);
    end
    sel_w[8] = pick(cfg_s[CFG_BLINK_EN], cfg_s[CFG_BLINK_FLIP], blink_in,
                    cfg_s[CFG_NINTH_PH0], cfg_s[CFG_NINTH_PH1]);
  end

  always_comb begin
    level_w = 9'h000;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (!pwm_on || eff_int[i] == INT_STATIC) begin
        level_w[i] = sel_w[i]; // see RQ6, RQ14
      // off-time shows the inverse, so a 0 bit keeps 1/16 even at the lowest setting
      end else if (in_on_time(slot_q, cyc_q, mst_s[7:4], eff_int[i])) begin
        level_w[i] = sel_w[i]; // see RQ4, RQ5, RQ12, RQ20
      end else begin
        level_w[i] = ~sel_w[i]; // see RQ7, RQ8, RQ20
      end
    end
  end

  // open drain: a 0 level drives low, a 1 floats
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_q <= 9'h000;
    end else begin
      oe_q <= ~level_w; // see RQ17
    end
  end

  assign port_oe   = oe_q[7:0];
  assign ninth_oe  = oe_q[8];
  assign port_out  = 8'h00;
  assign ninth_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  phase_zero_sel_a: assert property ((!pwm_on && !cfg_s[CFG_BLINK_EN]) // see RQ1
    |=> port_oe == ~$past(ph0_s)) else $error("phase zero not used with blink off");
  blink_phase_a: assert property ((!pwm_on && cfg_s[CFG_BLINK_EN] // see RQ2
    && (cfg_s[CFG_BLINK_FLIP] ^ blink_in)) |=> port_oe == ~$past(ph1_s))
    else $error("phase one not selected");
  period_wrap_a: assert property ((tick && cyc_q == 4'hF && slot_q == 4'hE) // see RQ3
    |=> cyc_q == 4'h0 && slot_q == 4'h0) else $error("period not 240 steps");
  master_gate_a: assert property ((pwm_on && slot_q >= mst_s[7:4] // see RQ4
    && eff_int[0] != 4'hF) |=> port_oe[0] == $past(sel_w[0]))
    else $error("output active in gated-off timeslot");
  on_time_a: assert property ((pwm_on && slot_q < mst_s[7:4] && cyc_q <= eff_int[0]) // see RQ5
    |=> port_oe[0] == !$past(sel_w[0])) else $error("on-time level wrong");
  static_full_a: assert property ((eff_int[1] == 4'hF) // see RQ6
    |=> port_oe[1] == !$past(sel_w[1])) else $error("full intensity not static");
  first_cycle_a: assert property ((pwm_on && cyc_q == 4'h0 && slot_q == 4'h0 // see RQ7
    && !sel_w[2]) |=> port_oe[2]) else $error("low phase bit never on");
  off_static_a: assert property ((sel_w[3] && eff_int[3] == 4'hF) // see RQ8
    |=> !port_oe[3]) else $error("high phase bit not fully off");
  global_int_a: assert property (cfg_s[CFG_GLOBAL] // see RQ11
    |-> eff_int[4] == mst_s[3:0] && eff_int[7] == mst_s[3:0])
    else $error("global intensity not applied");
  static_mode_a: assert property ((!pwm_on) // see RQ14
    |=> {ninth_oe, port_oe} == ~$past(sel_w)) else $error("outputs not static");
  osc_stop_a: assert property ((!osc_run) |=> !tick && div_q == 9'h000 // see RQ19
    && cyc_q == 4'h0) else $error("oscillator runs while pwm unused");
  shadow_hold_a: assert property ((osc_run && !(tick && cyc_q == 4'hF)) // see RQ21
    |=> $stable(ph0_s) && $stable(int_s)) else $error("setting changed mid-cycle");

  ////////////////////////////////////////////////////////////////////////////
  // counter, gating, shadow, global-mode, blink, open-drain and register checks
  cyc_step_a: assert property ((tick && cyc_q != 4'hF) // see RQ3
    |=> cyc_q == $past(cyc_q) + 4'h1 && slot_q == $past(slot_q))
    else $error("cycle counter did not step");
  slot_step_a: assert property ((tick && cyc_q == 4'hF && slot_q != 4'hE) // see RQ3
    |=> slot_q == $past(slot_q) + 4'h1) else $error("timeslot did not step");
  div_wrap_a: assert property (tick |=> div_q == 9'h000) // see RQ19
    else $error("divider not restarted after tick");
  ninth_gate_a: assert property ((pwm_on && slot_q >= mst_s[7:4] // see RQ4
    && eff_int[8] != 4'hF) |=> ninth_oe == $past(sel_w[8]))
    else $error("ninth output active in gated-off timeslot");
  off_time_a: assert property ((pwm_on && slot_q < mst_s[7:4] // see RQ20
    && cyc_q > eff_int[1]) |=> port_oe[1] == $past(sel_w[1]))
    else $error("off-time level not inverted");
  shadow_load_a: assert property ((tick && cyc_q == 4'hF) // see RQ21
    |=> mst_s == $past(master_q) && ph0_s == $past(phase_zero_q))
    else $error("settings not taken at boundary");
  ninth_int_a: assert property (!cfg_s[CFG_GLOBAL] // see RQ11
    |-> eff_int[8] == mst_s[3:0]) else $error("ninth intensity not from master register");
  global_on_a: assert property ((pwm_on && cfg_s[CFG_GLOBAL] // see RQ12
    && slot_q < mst_s[7:4] && cyc_q <= mst_s[3:0]) |=> port_oe == ~$past(sel_w[7:0]))
    else $error("global on-time level wrong");
  global_off_a: assert property ((pwm_on && cfg_s[CFG_GLOBAL] && mst_s[3:0] != 4'hF // see RQ16
    && slot_q < mst_s[7:4] && cyc_q > mst_s[3:0]) |=> port_oe == $past(sel_w[7:0]))
    else $error("port intensity used in global mode");
  blink_off_a: assert property (!cfg_s[CFG_BLINK_EN] // see RQ18
    |-> sel_w[7:0] == ph0_s) else $error("flip flag used with blink off");
  open_drain_a: assert property (port_out == 8'h00 && !ninth_out) // see RQ17
    else $error("open-drain output driven high");
  read_ph0_a: assert property ((reg_rd && reg_addr == REG_PHASE_ZERO) // see RQ9
    |=> reg_rdata == $past(phase_zero_q)) else $error("phase-zero readback wrong");
  read_ph1_a: assert property ((reg_rd && reg_addr == REG_PHASE_ONE) // see RQ10
    |=> reg_rdata == $past(phase_one_q)) else $error("phase-one readback wrong");
  write_ph0_a: assert property ((reg_wr && reg_addr == REG_PHASE_ZERO) // see RQ9
    |=> phase_zero_q == $past(reg_wdata)) else $error("phase-zero write lost");

  global_run_c: cover property (pwm_on && cfg_s[CFG_GLOBAL] && slot_q == 4'hE);
  blink_one_c:  cover property (cfg_s[CFG_BLINK_EN] && (cfg_s[CFG_BLINK_FLIP] ^ blink_in));
  wrap_c:       cover property (tick && cyc_q == 4'hF && slot_q == 4'hE);
  global_full_c: cover property (pwm_on && cfg_s[CFG_GLOBAL] && mst_s[7:4] == 4'hF);
  mixed_pwm_c:  cover property (pwm_on && !cfg_s[CFG_GLOBAL] && eff_int[2] == 4'hF
    && eff_int[0] != 4'hF);
endmodule

//--- lpi_led_load.sv
// led or logic load model on the open-drain outputs, with pull-ups
`timescale 1ns/10ps
module lpi_led_load (
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe,
  input  wire logic       ninth_out,
  input  wire logic       ninth_oe,
  output logic      [8:0] pin_level
);
  ////////////////////////////////////////////////////////////////
  // a released pin floats up through its pull-up, never holds a stale level
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_level[k] = port_oe[k] ? port_out[k] : 1'b1;
    end
    pin_level[8] = ninth_oe ? ninth_out : 1'b1;
  end
endmodule

//--- lpi_pkg.sv
// constants for the led blink and pwm intensity block
package lpi_pkg;
  // register offsets
  localparam logic [7:0] REG_PHASE_ZERO   = 8'h02;
  localparam logic [7:0] REG_PHASE_ONE    = 8'h0A;
  localparam logic [7:0] REG_MASTER_NINTH = 8'h0E;
  localparam logic [7:0] REG_CONFIG       = 8'h0F;
  localparam logic [7:0] REG_PORT_INT_0   = 8'h10;
  localparam logic [7:0] REG_PORT_INT_3   = 8'h13;
  // configuration register bit positions
  localparam int CFG_BLINK_EN    = 0;
  localparam int CFG_BLINK_FLIP  = 1;
  localparam int CFG_GLOBAL      = 2;
  localparam int CFG_NINTH_PH0   = 4;
  localparam int CFG_NINTH_PH1   = 5;
  localparam int CFG_BLINK_STAT  = 6;
  // values after reset
  localparam logic [7:0]  PHASE_RST  = 8'hFF;
  localparam logic [7:0]  CONFIG_RST = 8'h30;
  localparam logic [7:0]  MASTER_RST = 8'h00;
  localparam logic [31:0] INT_RST    = 32'h0000_0000;
  // timing
  localparam int CLK_HZ           = 10_000_000;
  localparam int OSC_HZ           = 32_000;
  localparam int OSC_DIV          = CLK_HZ / OSC_HZ;
  localparam logic [8:0] OSC_LAST = 9'(OSC_DIV - 1);
  localparam logic [3:0] CYC_LAST  = 4'hF;
  localparam logic [3:0] SLOT_LAST = 4'hE;
  localparam logic [3:0] INT_STATIC = 4'hF;
  localparam int NUM_OUT = 9;
endpackage

//--- tb_led_blink_pwm_intensity.sv
// self-checking bench for the led blink and pwm intensity block
`timescale 1ns/10ps
module tb_led_blink_pwm_intensity;
  import lpi_pkg::*;
  logic       core_clk  = 1'b0;
  logic       reset_n   = 1'b0;
  logic       blink_in  = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] port_out;
  logic [7:0] port_oe;
  logic       ninth_out;
  logic       ninth_oe;
  logic       pwm_running;
  logic [8:0] pin_level;
  int         n_fail    = 0;
  int         compares  = 0;

  always #50 core_clk = ~core_clk;

  lpi_core u_dut (.core_clk(core_clk), .reset_n(reset_n), .blink_in(blink_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_out(port_out), .port_oe(port_oe),
    .ninth_out(ninth_out), .ninth_oe(ninth_oe), .pwm_running(pwm_running));
  lpi_led_load u_load (.port_out(port_out), .port_oe(port_oe), .ninth_out(ninth_out),
    .ninth_oe(ninth_oe), .pin_level(pin_level));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk({24'h0000_00, reg_rdata}, {24'h0000_00, exp});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic test_regs();
    rd(8'h02, 8'hFF);
    rd(8'h0A, 8'hFF);
    rd(8'h0E, 8'h00);
    wr(8'h02, 8'hA5);
    wr(8'h0A, 8'h3C);
    rd(8'h02, 8'hA5);
    rd(8'h0A, 8'h3C);
    rd(8'h40, 8'h00);
    rd(8'h0F, 8'h30);
    wr(8'h12, 8'h5A);
    rd(8'h12, 8'h5A);
    wr(8'h12, 8'h00);
    $display("register test done");
  endtask

  // master nibble zero keeps every output static, so pins follow at once
  task automatic test_blink();
    logic e, b, p, sel;
    wr(8'h02, 8'h0F);
    wr(8'h0A, 8'hF0);
    wr(8'h0E, 8'h0F);
    for (int i = 0; i < 8; i++) begin
      e = i[0];
      b = i[1];
      p = i[2];
      sel = e & (b ^ p);
      wr(8'h0F, {6'b00_0100, b, e});
      blink_in <= p;
      repeat (4) @(posedge core_clk);
      #1 chk({23'h0, pin_level}, sel ? 32'h0000_00F0 : 32'h0000_010F);
      chk({31'h0, pwm_running}, 32'h0000_0000);
      rd(8'h0F, {1'b0, p, 4'b0100, b, e});
    end
    wr(8'h0F, 8'h30);
    blink_in <= 1'b0;
    $display("blink select test done");
  endtask

  // one whole pwm period counted; the window start does not matter
  task automatic test_pwm();
    int lo[9];
    int ticks[9];
    ticks = '{2, 30, 240, 238, 2, 2, 2, 2, 238};
    lo = '{default: 0};
    wr(8'h02, 8'h08);
    wr(8'h10, 8'hE0);
    wr(8'h11, 8'h0F);
    wr(8'h0E, 8'h20);
    repeat (16 * 312 + 8) @(posedge core_clk);
    #1 chk({31'h0, pwm_running}, 32'h0000_0001);
    for (int n = 0; n < 240 * 312; n++) begin
      @(posedge core_clk);
      #1;
      for (int k = 0; k < 9; k++) begin
        if (pin_level[k] == 1'b0) begin
          lo[k]++;
        end
      end
    end
    for (int k = 0; k < 9; k++) begin
      chk(lo[k], ticks[k] * 312);
    end
    $display("pwm duty test done");
  endtask

  // master 0xF gates every timeslot, so the waveform repeats every 16 ticks
  task automatic test_global();
    int lo[9];
    int ticks[9];
    ticks = '{4, 4, 4, 12, 4, 4, 4, 4, 12};
    lo = '{default: 0};
    wr(8'h0F, 8'h34);
    wr(8'h0E, 8'hF3);
    repeat (16 * 312 + 8) @(posedge core_clk);
    for (int n = 0; n < 16 * 312; n++) begin
      @(posedge core_clk);
      #1;
      for (int k = 0; k < 9; k++) begin
        if (pin_level[k] == 1'b0) begin
          lo[k]++;
        end
      end
    end
    for (int k = 0; k < 9; k++) begin
      chk(lo[k], ticks[k] * 312);
    end
    $display("global intensity test done");
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    test_regs();
    test_blink();
    test_pwm();
    test_global();
    stop_test();
  end

  // the run needs about 90k clocks; allow some margin
  initial begin
    #10_000_000;
    n_fail++;
    stop_test();
  end
endmodule
